// file: common/acs_pkg.sv
`default_nettype none
package acs_pkg;
  // Bus geometry
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_DATA      = 8'h04;
  localparam logic [7:0]  OFF_BAUD      = 8'h08;
  localparam logic [7:0]  OFF_STAT      = 8'h0C;

  // Control/status field positions
  localparam int          CTL_TX_EN     = 0;
  localparam int          CTL_TX_SEL    = 1;
  localparam int          CTL_LEN8      = 2;
  localparam int          CTL_PAR_EN    = 3;
  localparam int          CTL_PAR_EVEN  = 4;
  localparam int          CTL_RX_EN     = 5;
  localparam int          CTL_SEMA      = 6;
  localparam int          CTL_RX_ERR    = 7;
  localparam logic [7:0]  CTL_RST       = 8'h00;

  // Status register field positions
  localparam int          ST_TX_IRQ     = 0;
  localparam int          ST_RX_IRQ     = 1;
  localparam int          ST_HOLD_FULL  = 2;
  localparam int          ST_TX_BUSY    = 3;
  localparam int          ST_RX_BUSY    = 4;

  // Timing: baud tick divisor (tick period = divisor + 1 clocks), 16 ticks per bit
  localparam logic [15:0] BAUD_DIV_RST  = 16'h000C;
  localparam logic [3:0]  TICK_LAST     = 4'hF;
  localparam logic [3:0]  TICK_HALF     = 4'h7;
  localparam logic [3:0]  TX_BITS_7     = 4'hA;
  localparam logic [3:0]  TX_BITS_8     = 4'hB;
  localparam logic [3:0]  RX_BITS_7     = 4'h7;
  localparam logic [3:0]  RX_BITS_8     = 4'h8;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100
  } acs_rx_state_t;
endpackage
`default_nettype wire

// file: src/acs_serial_channel.sv
// Operation
// - Transmit enable on runs transmitter, its interrupt and the out pin; reset clears it.
// - Clearing transmit enable clears interrupt select, stops transmitter, interrupt and pin drive.
// - Select 0: interrupt on data register empty; select 1: data and shifter empty.
// - Writing a new transmit character removes the pending transmit interrupt.
// - Length bit 0: 7 data bits, 10-bit transmit frame with parity or two stops.
// - Seven-bit mode drops bit 7 of a written character.
// - Seven-bit mode reads bit 7 of received data as zero.
// - Length bit 1: 8 data bits, 11-bit transmit frame with parity or two stops.
// - Receiver takes start, data, optional parity and one stop bit.
// - Parity enable turns parity on for both directions; reset clears it.
// - Polarity 0 means odd parity, 1 means even, over data plus parity.
// - Receive enable runs receiver; interrupt raised on each shifter-to-data transfer.
// - Reading received data removes the receive interrupt.
// - Input pin reaches the receiver only while receive enable is 1.
// - Receive enable 0 halts and clears receive logic; data bits 0-6 kept, bit 7 cleared.
// - Semaphore bit is plain read/write, no effect, cleared by reset.
// - Sticky error flag set by parity, framing or overrun error.
// - Parity error when received parity bit mismatches computed parity.
// - Framing error when stop bit is sampled low.
// - Overrun when a character transfers while previous one is unread.
// - Error flag cleared by reset or writing 1; writing 0 leaves it.
// - Reset clears length, polarity and receive enable bits.
// - Each bit period is sixteen baud ticks.
// - Start must stay low half a bit before assembly; bits sampled at centre.
// - One data address: writes load transmit register, reads return received data.
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`default_nettype none
module acs_serial_channel (
  input  wire logic                         clock,
  input  wire logic                         rst,
  input  wire logic [acs_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [acs_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [acs_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [acs_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         serialInPin,
  output logic                              serialOutPin,
  output logic                              serialOutPinEn,
  output logic                              serialTxInterrupt,
  output logic                              serialRxInterrupt
);
  // ---------------- Bus slave ----------------
  logic                        awHave_q;
  logic [acs_pkg::ADDR_W-1:0]  awAddr_q;
  logic                        wHave_q;
  logic [7:0]                  wData_q;
  logic [1:0]                  wStrb_q;
  logic                        awHave_d;
  logic                        wHave_d;
  logic                        doWrite;
  logic                        arTake;
  logic                        rvalid_d;
  logic                        wrCtrl;
  logic                        wrData;
  logic                        wrBaudLo;
  logic                        wrBaudHi;
  logic                        rdData;
  logic [acs_pkg::DATA_W-1:0]  readValue;
  logic                        readOk;
  logic [7:0]                  wByteHi_q;

  // Control/status state
  logic [6:0]  ctrl_q;
  logic        rxErr_q;
  logic [15:0] baudDiv_q;
  logic [15:0] baudCnt_q;
  logic        tick_q;

  // Transmitter state
  logic [7:0]  txHold_q;
  logic        txHoldFull_q;
  logic [10:0] txShift_q;
  logic        txBusy_q;
  logic [3:0]  txTick_q;
  logic [3:0]  txBitsLeft_q;
  logic        txLoad;
  logic        txParity;
  logic [10:0] txFrame;

  // Receiver state
  logic [2:0]             inSync_q;
  logic                   rxLine_q;
  logic                   rxSample;
  acs_pkg::acs_rx_state_t rxState_q;
  logic [3:0]             rxTick_q;
  logic [3:0]             rxBitCnt_q;
  logic [7:0]             rxShift_q;
  logic                   rxParErr_q;
  logic [7:0]             rxData_q;
  logic                   rxFull_q;
  logic                   rxXfer;
  logic                   rxFrameErr;
  logic                   rxOverrun;
  logic [7:0]             rxAssembled;

  logic txEn;
  logic txSel;
  logic len8;
  logic parEn;
  logic parEven;
  logic rxEn;

  assign txEn    = ctrl_q[acs_pkg::CTL_TX_EN];
  assign txSel   = ctrl_q[acs_pkg::CTL_TX_SEL];
  assign len8    = ctrl_q[acs_pkg::CTL_LEN8];
  assign parEn   = ctrl_q[acs_pkg::CTL_PAR_EN];
  assign parEven = ctrl_q[acs_pkg::CTL_PAR_EVEN];
  assign rxEn    = ctrl_q[acs_pkg::CTL_RX_EN];

  assign doWrite  = awHave_q && wHave_q && !s_axi_bvalid;
  assign awHave_d = doWrite ? 1'b0 : (awHave_q || (s_axi_awvalid && s_axi_awready));
  assign wHave_d  = doWrite ? 1'b0 : (wHave_q || (s_axi_wvalid && s_axi_wready));
  assign arTake   = s_axi_arvalid && s_axi_arready;
  assign rvalid_d = arTake || (s_axi_rvalid && !s_axi_rready);

  assign wrCtrl   = doWrite && (awAddr_q == acs_pkg::OFF_CTRL) && wStrb_q[0];
  assign wrData   = doWrite && (awAddr_q == acs_pkg::OFF_DATA) && wStrb_q[0];
  assign wrBaudLo = doWrite && (awAddr_q == acs_pkg::OFF_BAUD) && wStrb_q[0];
  assign wrBaudHi = doWrite && (awAddr_q == acs_pkg::OFF_BAUD) && wStrb_q[1];
  assign rdData   = arTake && (s_axi_araddr == acs_pkg::OFF_DATA);

  always_ff @(posedge clock) begin
    if (rst) begin
      awHave_q      <= 1'b0;
      wHave_q       <= 1'b0;
      awAddr_q      <= '0;
      wData_q       <= 8'h00;
      wByteHi_q     <= 8'h00;
      wStrb_q       <= 2'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= acs_pkg::RESP_OKAY;
    end else begin
      awHave_q      <= awHave_d;
      wHave_q       <= wHave_d;
      s_axi_awready <= !awHave_d;
      s_axi_wready  <= !wHave_d;
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_q   <= s_axi_wdata[7:0];
        wByteHi_q <= s_axi_wdata[15:8];
        wStrb_q   <= s_axi_wstrb[1:0];
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_q == acs_pkg::OFF_CTRL || awAddr_q == acs_pkg::OFF_DATA ||
                         awAddr_q == acs_pkg::OFF_BAUD || awAddr_q == acs_pkg::OFF_STAT)
                        ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    readValue = '0;
    readOk    = 1'b1;
    case (s_axi_araddr)
      acs_pkg::OFF_CTRL: readValue[7:0]  = {rxErr_q, ctrl_q};
      acs_pkg::OFF_DATA: readValue[7:0]  = len8 ? rxData_q : {1'b0, rxData_q[6:0]};
      acs_pkg::OFF_BAUD: readValue[15:0] = baudDiv_q;
      acs_pkg::OFF_STAT: readValue[4:0]  = {rxState_q != acs_pkg::RX_IDLE, txBusy_q, txHoldFull_q,
                                            rxFull_q, serialTxInterrupt};
      default:           readOk          = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= acs_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !rvalid_d;
      s_axi_rvalid  <= rvalid_d;
      if (arTake) begin
        s_axi_rdata <= readValue;
        s_axi_rresp <= readOk ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
      end
    end
  end

  // ---------------- Control register ----------------
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q <= acs_pkg::CTL_RST[6:0];
    end else if (wrCtrl) begin
      ctrl_q    <= wData_q[6:0];
      ctrl_q[acs_pkg::CTL_TX_SEL] <= wData_q[acs_pkg::CTL_TX_SEL] & wData_q[acs_pkg::CTL_TX_EN];
    end
  end

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge clock) begin
    if (rst) begin
      rxErr_q <= 1'b0;
    end else if (rxXfer && (rxFrameErr || rxParErr_q || rxOverrun)) begin
      rxErr_q <= 1'b1;
    end else if (wrCtrl && wData_q[acs_pkg::CTL_RX_ERR]) begin
      rxErr_q <= 1'b0;
    end
  end

  // ---------------- Baud tick ----------------
  always_ff @(posedge clock) begin
    if (rst) begin
      baudDiv_q <= acs_pkg::BAUD_DIV_RST;
    end else begin
      if (wrBaudLo) begin
        baudDiv_q[7:0] <= wData_q;
      end
      if (wrBaudHi) begin
        baudDiv_q[15:8] <= wByteHi_q;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      baudCnt_q <= 16'h0000;
      tick_q    <= 1'b0;
    end else if (baudCnt_q >= baudDiv_q) begin
      baudCnt_q <= 16'h0000;
      tick_q    <= 1'b1;
    end else begin
      baudCnt_q <= baudCnt_q + 16'h0001;
      tick_q    <= 1'b0;
    end
  end

  // ---------------- Transmitter ----------------
  assign txParity = (len8 ? ^txHold_q : ^txHold_q[6:0]) ^ !parEven;
  always_comb begin
    txFrame = 11'h7FF;
    txFrame[0] = 1'b0;
    if (len8) begin
      txFrame[8:1] = txHold_q;
      txFrame[9]   = parEn ? txParity : 1'b1;
    end else begin
      txFrame[7:1] = txHold_q[6:0];
      txFrame[8]   = parEn ? txParity : 1'b1;
    end
  end
  assign txLoad = txEn && !txBusy_q && txHoldFull_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      txHold_q     <= 8'h00;
      txHoldFull_q <= 1'b0;
    end else if (wrData) begin
      txHold_q     <= len8 ? wData_q : {1'b0, wData_q[6:0]};
      txHoldFull_q <= 1'b1;
    end else if (txLoad) begin
      txHoldFull_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || !txEn) begin
      txBusy_q     <= 1'b0;
      txShift_q    <= 11'h7FF;
      txTick_q     <= 4'h0;
      txBitsLeft_q <= 4'h0;
    end else if (txLoad) begin
      txBusy_q     <= 1'b1;
      txShift_q    <= txFrame;
      txTick_q     <= 4'h0;
      txBitsLeft_q <= len8 ? acs_pkg::TX_BITS_8 : acs_pkg::TX_BITS_7;
    end else if (txBusy_q && tick_q) begin
      txTick_q <= txTick_q + 4'h1;
      if (txTick_q == acs_pkg::TICK_LAST) begin
        txShift_q    <= {1'b1, txShift_q[10:1]};
        txBitsLeft_q <= txBitsLeft_q - 4'h1;
        if (txBitsLeft_q == 4'h1) begin
          txBusy_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      serialOutPin      <= 1'b1;
      serialOutPinEn    <= 1'b0;
      serialTxInterrupt <= 1'b0;
    end else begin
      serialOutPin      <= txBusy_q ? txShift_q[0] : 1'b1;
      serialOutPinEn    <= txEn;
      serialTxInterrupt <= txEn && !txHoldFull_q && !wrData &&
                           (!txSel || !txBusy_q);
    end
  end

  // ---------------- Receiver ----------------
  // Fourth stage filters: line moves only once stages two and three agree
  always_ff @(posedge clock) begin
    if (rst) begin
      inSync_q <= 3'h7;
      rxLine_q <= 1'b1;
    end else begin
      inSync_q <= {inSync_q[1:0], serialInPin};
      if (inSync_q[1] == inSync_q[2]) begin
        rxLine_q <= inSync_q[2];
      end
    end
  end
  assign rxSample = rxEn ? rxLine_q : 1'b1;

  assign rxAssembled = len8 ? rxShift_q : {1'b0, rxShift_q[7:1]};
  assign rxXfer      = (rxState_q == acs_pkg::RX_STOP) && tick_q && (rxTick_q == acs_pkg::TICK_LAST);
  assign rxFrameErr  = !rxSample;
  assign rxOverrun   = rxFull_q && !rdData;

  always_ff @(posedge clock) begin
    if (rst || !rxEn) begin
      rxState_q  <= acs_pkg::RX_IDLE;
      rxTick_q   <= 4'h0;
      rxBitCnt_q <= 4'h0;
      rxShift_q  <= 8'h00;
      rxParErr_q <= 1'b0;
    end else if (tick_q) begin
      rxTick_q <= rxTick_q + 4'h1;
      case (rxState_q)
        acs_pkg::RX_IDLE: begin
          rxTick_q   <= 4'h0;
          rxParErr_q <= 1'b0;
          rxBitCnt_q <= 4'h0;
          if (!rxSample) begin
            rxState_q <= acs_pkg::RX_START;
          end
        end
        acs_pkg::RX_START: begin
          if (rxSample) begin
            rxState_q <= acs_pkg::RX_IDLE;
          end else if (rxTick_q == acs_pkg::TICK_HALF) begin
            rxState_q <= acs_pkg::RX_DATA;
            rxTick_q  <= 4'h0;
          end
        end
        acs_pkg::RX_DATA: begin
          if (rxTick_q == acs_pkg::TICK_LAST) begin
            rxShift_q  <= {rxSample, rxShift_q[7:1]};
            rxBitCnt_q <= rxBitCnt_q + 4'h1;
            if (rxBitCnt_q == (len8 ? acs_pkg::RX_BITS_8 : acs_pkg::RX_BITS_7) - 4'h1) begin
              rxState_q <= parEn ? acs_pkg::RX_PAR : acs_pkg::RX_STOP;
            end
          end
        end
        acs_pkg::RX_PAR: begin
          if (rxTick_q == acs_pkg::TICK_LAST) begin
            rxParErr_q <= ((^rxAssembled) ^ rxSample) == parEven;
            rxState_q  <= acs_pkg::RX_STOP;
          end
        end
        acs_pkg::RX_STOP: begin
          if (rxTick_q == acs_pkg::TICK_LAST) begin
            rxState_q <= acs_pkg::RX_IDLE;
          end
        end
        default: begin
          rxState_q <= acs_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Set wins over a same-cycle read clear
  always_ff @(posedge clock) begin
    if (rst) begin
      rxData_q <= 8'h00;
      rxFull_q <= 1'b0;
    end else if (!rxEn) begin
      rxData_q[7] <= 1'b0;
      rxFull_q    <= 1'b0;
    end else if (rxXfer) begin
      rxData_q <= rxAssembled;
      rxFull_q <= 1'b1;
    end else if (rdData) begin
      rxFull_q <= 1'b0;
    end
  end
  assign serialRxInterrupt = rxFull_q;
endmodule
`default_nettype wire

// file: verif/acs_serial_props.sv
`default_nettype none
module acs_serial_props (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        serialOutPin,
  input wire logic        serialOutPinEn,
  input wire logic        serialTxInterrupt,
  input wire logic        serialRxInterrupt
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Bench always offers address and data together
  wire wrTaken = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire ctrlWr  = wrTaken && s_axi_awaddr == acs_pkg::OFF_CTRL;

  property p_reset_quiet;
    disable iff (1'b0) rst |=> !s_axi_bvalid && !s_axi_rvalid && !serialOutPinEn && !serialTxInterrupt
      && !serialRxInterrupt;
  endproperty
  // Write lands one edge after the take, response shows one edge later
  property p_b_after; wrTaken |-> ##2 s_axi_bvalid; endproperty
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  property p_r_after; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_tx_irq_gate; !serialOutPinEn |-> !serialTxInterrupt; endproperty
  property p_data_wr; wrTaken && s_axi_awaddr == acs_pkg::OFF_DATA |-> ##[1:3] !serialTxInterrupt; endproperty
  property p_data_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == acs_pkg::OFF_DATA |-> ##[1:3] !serialRxInterrupt;
  endproperty
  property p_tx_off; ctrlWr && !s_axi_wdata[acs_pkg::CTL_TX_EN] |-> ##[1:3] !serialOutPinEn; endproperty
  property p_rx_off; ctrlWr && !s_axi_wdata[acs_pkg::CTL_RX_EN] |-> ##[1:3] !serialRxInterrupt; endproperty
  property p_start_len;
    serialOutPinEn && $fell(serialOutPin) |-> (!serialOutPin || !serialOutPinEn) [*8];
  endproperty

  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
  a_b_after: assert property (p_b_after) else $error("no write response");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_after: assert property (p_r_after) else $error("no read response");
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  a_tx_irq_gate: assert property (p_tx_irq_gate) else $error("tx interrupt while disabled");
  a_data_wr: assert property (p_data_wr) else $error("tx interrupt kept after data write");
  a_data_rd: assert property (p_data_rd) else $error("rx interrupt kept after data read");
  a_tx_off: assert property (p_tx_off) else $error("out pin still driven");
  a_rx_off: assert property (p_rx_off) else $error("rx interrupt kept with receiver off");
  a_start_len: assert property (p_start_len) else $error("start bit too short");

  c_write: cover property (wrTaken);
  c_rx_full: cover property ($rose(serialRxInterrupt));
  c_tx_irq: cover property ($rose(serialTxInterrupt));
endmodule

bind acs_serial_channel acs_serial_props u_props (
  .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .serialOutPin, .serialOutPinEn, .serialTxInterrupt, .serialRxInterrupt
);
`default_nettype wire

// file: verif/acs_remote_uart.sv
`default_nettype none
module acs_remote_uart #(
  parameter int BIT = 16
) (
  input  wire logic   clock,
  input  wire logic   line,
  output logic        serialInPin,
  output logic [10:0] rxBits,
  output int          rxFrames
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serialInPin = 1'b1;
    rxFrames = 0;
  end

  // Frame bits in line order, bit 0 is the start bit
  task automatic send(input logic [10:0] f);
    for (int i = 0; i < 11; i++) begin
      serialInPin <= f[i];
      repeat (BIT) @(posedge clock);
    end
    // Idle level, then one edge so a following frame never drives the pin twice at once
    serialInPin <= 1'b1;
    @(posedge clock);
  endtask

  // Samples eleven bit centres; a 7-bit frame's last sample is idle line
  always begin
    // Unknown line at start-up must not look like a start bit
    wait (line === 1'b1);
    @(negedge line);
    repeat (BIT / 2) @(posedge clock);
    for (int i = 0; i < 11; i++) begin
      rxBits[i] = line;
      repeat (BIT) @(posedge clock);
    end
    rxFrames++;
  end
endmodule
`default_nettype wire

// file: verif/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 16;  // Divisor 0 gives one tick a clock
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic        serialInPin;
  logic        serialOutPin;
  logic        serialOutPinEn;
  logic        serialTxInterrupt;
  logic        serialRxInterrupt;
  logic [10:0] rxBits;
  int          rxFrames;
  int          failures = 0;
  int          checkCount = 0;
  logic [31:0] rd;
  logic [1:0]  resp;
  wire         line = serialOutPinEn ? serialOutPin : 1'b1;  // Released line pulled high

  always #20 clock = ~clock;

  acs_serial_channel DUT (
    .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serialInPin, .serialOutPin, .serialOutPinEn,
    .serialTxInterrupt, .serialRxInterrupt
  );
  acs_remote_uart #(.BIT(BIT)) remote (.clock, .line, .serialInPin, .rxBits, .rxFrames);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask

  task automatic rdt(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  function automatic logic [10:0] frame(logic [7:0] d, logic [7:0] c);
    logic [10:0] f;
    logic        l8;
    l8 = c[acs_pkg::CTL_LEN8];
    f = 11'h7FF;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++)
      if (i < 7 || l8) f[i+1] = d[i];
    if (c[acs_pkg::CTL_PAR_EN]) f[8+l8] = ^f[7:1] ^ (l8 & d[7]) ^ !c[acs_pkg::CTL_PAR_EVEN];
    return f;
  endfunction

  initial begin
    repeat (60000) @(posedge clock);
    failures++;
    print_verdict();
  end

  initial begin
    logic [7:0]  c;
    logic [7:0]  d;
    logic [10:0] f;
    int          n;
    void'($urandom(83017));
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rdt(acs_pkg::OFF_CTRL);
    check(rd, 32'h0);
    rdt(8'h10);
    check(rd, 32'h0);
    check(resp, acs_pkg::RESP_SLVERR);
    wr(8'h10, 32'h0);
    check(resp, acs_pkg::RESP_SLVERR);
    wr(acs_pkg::OFF_BAUD, 32'h0);
    check(resp, acs_pkg::RESP_OKAY);
    wr(acs_pkg::OFF_CTRL, 32'h40);
    rdt(acs_pkg::OFF_CTRL);
    check(rd, 32'h40);
    wr(acs_pkg::OFF_CTRL, 32'h03);
    wr(acs_pkg::OFF_CTRL, 32'h02);
    rdt(acs_pkg::OFF_CTRL);
    check(rd, 32'h0);
    check(serialOutPinEn, 1'b0);
    for (int k = 0; k < 8; k++) begin
      c = (k == 0) ? 8'h05 : (k == 1) ? 8'h19 : {3'h0, 4'($urandom), 1'b1};
      d = (k == 0) ? 8'hFF : (k == 1) ? 8'h80 : 8'($urandom);
      n = rxFrames;
      wr(acs_pkg::OFF_CTRL, {24'h0, c});
      wr(acs_pkg::OFF_DATA, {24'h0, d});
      repeat (3 * BIT) @(posedge clock);
      check(serialTxInterrupt, !c[acs_pkg::CTL_TX_SEL]);
      // Mid-frame status: shifter busy, data register empty, receiver idle
      rdt(acs_pkg::OFF_STAT);
      check(rd, {27'h0, 4'h4, !c[acs_pkg::CTL_TX_SEL]});
      for (int t = 0; t < 400 && rxFrames == n; t++) @(posedge clock);
      check(rxBits, frame(d, c));
      repeat (2 * BIT) @(posedge clock);
      check(serialTxInterrupt, 1'b1);
    end
    for (int k = 0; k < 8; k++) begin
      c = (k == 0) ? 8'h24 : (k == 1) ? 8'h28 : {3'h1, 4'($urandom), 1'b0};
      d = (k == 0) ? 8'hA5 : (k == 1) ? 8'hFF : 8'($urandom);
      wr(acs_pkg::OFF_CTRL, {24'h0, c});
      remote.send(frame(d, c));
      for (int t = 0; t < 100 && !serialRxInterrupt; t++) @(posedge clock);
      check(serialRxInterrupt, 1'b1);
      rdt(acs_pkg::OFF_DATA);
      check(rd, {24'h0, c[acs_pkg::CTL_LEN8] ? d : {1'b0, d[6:0]}});
      rdt(acs_pkg::OFF_CTRL);
      check(rd[7], 1'b0);
      check(serialRxInterrupt, 1'b0);
    end
    // Parity, framing and overrun in turn
    for (int k = 0; k < 3; k++) begin
      c = 8'h28;
      f = frame(8'h5A, c);
      if (k == 0) f[8] = !f[8];
      if (k == 1) f[9] = 1'b0;
      wr(acs_pkg::OFF_CTRL, {24'h0, c});
      remote.send(f);
      if (k == 2) remote.send(f);
      rdt(acs_pkg::OFF_DATA);
      wr(acs_pkg::OFF_CTRL, {24'h0, c});
      rdt(acs_pkg::OFF_CTRL);
      check(rd, {24'h0, c | 8'h80});
      wr(acs_pkg::OFF_CTRL, {24'h0, c | 8'h80});
      rdt(acs_pkg::OFF_CTRL);
      check(rd, {24'h0, c});
    end
    wr(acs_pkg::OFF_CTRL, 32'h24);
    remote.send(frame(8'hC3, 8'h24));
    wr(acs_pkg::OFF_CTRL, 32'h04);
    repeat (2) @(posedge clock);
    check(serialRxInterrupt, 1'b0);
    rdt(acs_pkg::OFF_DATA);
    check(rd, 32'h43);
    remote.send(frame(8'h11, 8'h24));
    check(serialRxInterrupt, 1'b0);
    rdt(acs_pkg::OFF_DATA);
    check(rd, 32'h43);
    print_verdict();
  end
endmodule
`default_nettype wire
